// ===== core/trs_defs.svh
// timing constants for the triple rail sequencer
`ifndef TRS_DEFS_SVH
`define TRS_DEFS_SVH
`define TRS_CLK_HZ         100000000
`define TRS_OSC_HZ         250000
// boost period in system clock cycles
`define TRS_OSC_CYC        (`TRS_CLK_HZ / `TRS_OSC_HZ)
// maximum duty cycle, percent (lower bound of the allowed band)
`define TRS_MAX_DUTY_PCT   79
`define TRS_MAX_ON_CYC     ((`TRS_OSC_CYC * `TRS_MAX_DUTY_PCT) / 100)
// pump soft-start time in ms
`define TRS_SS_MS          16
`define TRS_SS_CYC         ((`TRS_CLK_HZ / 1000) * `TRS_SS_MS)
// soft-start duty steps
`define TRS_SS_STEPS       16
`endif

// ===== core/trs_pkg.sv
// types for the triple rail sequencer
`default_nettype none
package trs_pkg;
    typedef enum logic [2:0] {
        TRS_OFF,
        TRS_REF,
        TRS_MAIN,
        TRS_NEG,
        TRS_POS,
        TRS_READY
    } trs_state_e;
endpackage
`default_nettype wire

// ===== core/trs_sequencer.sv
// sequencer, boost switch timing and pump phase logic
`timescale 1ns/1ps
`default_nettype none
`include "trs_defs.svh"
module trs_sequencer
    import trs_pkg::*;
#(
    parameter int OSC_CYC    = `TRS_OSC_CYC,
    parameter int MAX_ON_CYC = `TRS_MAX_ON_CYC,
    parameter int SS_CYC     = `TRS_SS_CYC
)
(
    input  wire logic clk_sys,
    input  wire logic rst_b,
    input  wire logic power_off_n_input,
    input  wire logic ref_ok,
    input  wire logic boost_fb_ok,
    input  wire logic neg_fb_ok,
    input  wire logic neg_fb_fault,
    input  wire logic pos_fb_ok,
    input  wire logic pos_fb_fault,
    input  wire logic boost_trip,
    output logic      ref_enable,
    output logic      ref_ground,
    output logic      boost_enable,
    output logic      boost_switch_node,
    output logic      neg_pump_enable,
    output logic      neg_pump_driver_hi,
    output logic      neg_pump_driver_lo,
    output logic      pos_pump_enable,
    output logic      pos_pump_driver_hi,
    output logic      pos_pump_driver_lo,
    output logic      pump_ramp_active,
    output logic      ready_n_out,
    output logic      ready_n_oe
);
    localparam int NIN = 8;
    localparam int OCW = $clog2(OSC_CYC + 1);
    localparam int SSW = $clog2(SS_CYC + 1);

    // three-stage sync; accept a change when stages 2 and 3 agree
    logic [NIN-1:0] s1_r;
    logic [NIN-1:0] s2_r;
    logic [NIN-1:0] s3_r;
    logic [NIN-1:0] flt_r;
    logic [NIN-1:0] raw;
    assign raw = {boost_trip, pos_fb_fault, pos_fb_ok, neg_fb_fault,
                  neg_fb_ok, boost_fb_ok, ref_ok, power_off_n_input};

    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            s1_r  <= '0;
            s2_r  <= '0;
            s3_r  <= '0;
            flt_r <= '0;
        end
        else
        begin
            s1_r  <= raw;
            s2_r  <= s1_r;
            s3_r  <= s2_r;
            for (int i = 0; i < NIN; i++)
                if (s2_r[i] == s3_r[i])
                    flt_r[i] <= s3_r[i];
        end
    end

    logic on_q, ref_q, mainok_q, negok_q, negflt_q, posok_q, posflt_q, trip_q;
    assign {trip_q, posflt_q, posok_q, negflt_q, negok_q, mainok_q, ref_q,
            on_q} = flt_r;

    // sequence state
    trs_state_e st_r;
    trs_state_e st_nxt;

    always_comb
    begin
        st_nxt = st_r;
        unique case (st_r)
            TRS_OFF:   st_nxt = TRS_REF;
            TRS_REF:   if (ref_q) st_nxt = TRS_MAIN;
            TRS_MAIN:  if (!ref_q) st_nxt = TRS_REF;
                       else if (mainok_q) st_nxt = TRS_NEG;
            TRS_NEG:   if (!ref_q) st_nxt = TRS_REF;
                       else if (!mainok_q) st_nxt = TRS_MAIN;
                       else if (negok_q) st_nxt = TRS_POS;
            TRS_POS:   if (!ref_q) st_nxt = TRS_REF;
                       else if (!mainok_q) st_nxt = TRS_MAIN;
                       else if (negflt_q) st_nxt = TRS_NEG;
                       else if (posok_q) st_nxt = TRS_READY;
            TRS_READY: if (!ref_q) st_nxt = TRS_REF;
                       else if (!mainok_q) st_nxt = TRS_MAIN;
                       else if (negflt_q) st_nxt = TRS_NEG;
                       else if (posflt_q) st_nxt = TRS_POS;
        endcase
        if (!on_q)
            st_nxt = TRS_OFF;
    end

    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
            st_r <= TRS_OFF;
        else
            st_r <= st_nxt;
    end

    // stage enables follow the sequence position
    always_comb
    begin
        ref_enable      = (st_r != TRS_OFF);
        ref_ground      = (st_r == TRS_OFF);
        boost_enable    = (st_r >= TRS_MAIN);
        neg_pump_enable = (st_r >= TRS_NEG);
        pos_pump_enable = (st_r >= TRS_POS);
        ready_n_out     = 1'b0;
        ready_n_oe      = (st_r == TRS_READY);
    end

    // boost oscillator and switch latch
    logic [OCW-1:0] osc_r;
    logic           sw_r;
    logic           half_r;

    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
            osc_r <= '0;
        else if (osc_r == OCW'(OSC_CYC - 1))
            osc_r <= '0;
        else
            osc_r <= osc_r + OCW'(1);
    end

    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
            sw_r <= 1'b0;
        else if (!boost_enable)
            sw_r <= 1'b0;
        else if (osc_r == OCW'(OSC_CYC - 1))
            sw_r <= 1'b1;
        else if (trip_q || osc_r >= OCW'(MAX_ON_CYC - 1))
            sw_r <= 1'b0;
    end
    assign boost_switch_node = sw_r;

    // pump phase toggles each oscillator period: half rate
    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
            half_r <= 1'b0;
        else if (osc_r == OCW'(OSC_CYC - 1))
            half_r <= ~half_r;
    end

    // soft-start: low-side pump drive gated by a duty ramp over the ramp time
    logic [SSW-1:0] ss_r;
    logic [3:0]     gate_lvl;
    logic           pump_gate;

    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
            ss_r <= '0;
        else if (!neg_pump_enable)
            ss_r <= '0;
        else if (ss_r != SSW'(SS_CYC))
            ss_r <= ss_r + SSW'(1);
    end
    assign gate_lvl  = 4'(ss_r / SSW'(SS_CYC / `TRS_SS_STEPS + 1));
    assign pump_gate = (ss_r == SSW'(SS_CYC)) || (osc_r[3:0] <= gate_lvl);
    assign pump_ramp_active = neg_pump_enable && (ss_r != SSW'(SS_CYC));

    always_comb
    begin
        neg_pump_driver_hi = neg_pump_enable && !half_r;
        neg_pump_driver_lo = neg_pump_enable && half_r && pump_gate;
        pos_pump_driver_lo = pos_pump_enable && !half_r && pump_gate;
        pos_pump_driver_hi = pos_pump_enable && half_r;
    end

    // assertions: sequence order
    AST_OFF_DISABLES: assert property (@(posedge clk_sys)
        disable iff (!rst_b)
        !on_q |=> !boost_enable && !neg_pump_enable && ref_ground)
        else $error("stages active during shutdown");

    AST_REF_GROUND: assert property (@(posedge clk_sys)
        disable iff (!rst_b)
        ref_ground |-> !ref_enable && !boost_enable && !pos_pump_enable)
        else $error("reference grounded while stages run");

    AST_REF_FIRST: assert property (@(posedge clk_sys)
        disable iff (!rst_b)
        $rose(boost_enable) |-> ref_enable && $past(ref_enable))
        else $error("boost enabled before reference");

    AST_NEG_AFTER_MAIN: assert property (@(posedge clk_sys)
        disable iff (!rst_b)
        $rose(neg_pump_enable) |-> $past(mainok_q))
        else $error("negative pump before main regulated");

    AST_POS_AFTER_NEG: assert property (@(posedge clk_sys)
        disable iff (!rst_b)
        $rose(pos_pump_enable) |-> $past(negok_q) && neg_pump_enable)
        else $error("positive pump started early");

    AST_READY_CAUSE: assert property (@(posedge clk_sys)
        disable iff (!rst_b)
        $rose(ready_n_oe) |-> $past(posok_q) && pos_pump_enable)
        else $error("ready without positive rail good");

    AST_READY_OPEN_DRAIN: assert property (@(posedge clk_sys)
        disable iff (!rst_b)
        ready_n_oe |-> !ready_n_out)
        else $error("ready line driven high");

    // assertions: supervision after ready
    AST_FAULT_RELEASE: assert property (@(posedge clk_sys)
        disable iff (!rst_b)
        ready_n_oe && (posflt_q || negflt_q || !mainok_q || !ref_q)
            |=> !ready_n_oe)
        else $error("ready held through fault");

    // ref or main loss also drops the negative pump, so exclude them
    AST_NEG_FAULT_POS_OFF: assert property (@(posedge clk_sys)
        disable iff (!rst_b)
        pos_pump_enable && negflt_q && on_q && ref_q && mainok_q
            |=> !pos_pump_enable && neg_pump_enable)
        else $error("later stage kept running on fault");

    // assertions: boost switch timing
    AST_OSC_RANGE: assert property (@(posedge clk_sys)
        disable iff (!rst_b)
        osc_r < OCW'(OSC_CYC))
        else $error("oscillator count out of range");

    AST_SET_EDGE: assert property (@(posedge clk_sys)
        disable iff (!rst_b)
        boost_enable && $past(boost_enable) && osc_r == '0 |-> sw_r)
        else $error("switch not set at cycle start");

    AST_LATCH_STAYS_OFF: assert property (@(posedge clk_sys)
        disable iff (!rst_b)
        !sw_r && osc_r != OCW'(OSC_CYC - 1) |=> !sw_r)
        else $error("switch turned on mid cycle");

    AST_MAX_DUTY: assert property (@(posedge clk_sys)
        disable iff (!rst_b)
        sw_r |-> osc_r < OCW'(MAX_ON_CYC))
        else $error("switch on past maximum duty");

    // assertions: pump drivers
    AST_HALF_RATE: assert property (@(posedge clk_sys)
        disable iff (!rst_b)
        $changed(half_r) |-> osc_r == '0)
        else $error("pump phase off the oscillator edge");

    AST_NEG_DRV_EXCL: assert property (@(posedge clk_sys)
        disable iff (!rst_b)
        !(neg_pump_driver_hi && neg_pump_driver_lo))
        else $error("negative pump switches overlap");

    AST_POS_DRV_EXCL: assert property (@(posedge clk_sys)
        disable iff (!rst_b)
        !(pos_pump_driver_hi && pos_pump_driver_lo))
        else $error("positive pump switches overlap");

    AST_PUMPS_IDLE_OFF: assert property (@(posedge clk_sys)
        disable iff (!rst_b)
        !neg_pump_enable |-> !neg_pump_driver_hi && !neg_pump_driver_lo
            && !pos_pump_driver_hi && !pos_pump_driver_lo)
        else $error("pump driver active while disabled");

    AST_RAMP_BOUND: assert property (@(posedge clk_sys)
        disable iff (!rst_b)
        pump_ramp_active |-> neg_pump_enable && ss_r < SSW'(SS_CYC))
        else $error("pump ramp outside enable window");

    COV_READY: cover property (@(posedge clk_sys) $rose(ready_n_oe));
    COV_FAULT: cover property (@(posedge clk_sys) $fell(ready_n_oe));
    COV_TRIP:  cover property (@(posedge clk_sys) sw_r && trip_q ##1 !sw_r);
    COV_POWER_OFF_N_INPUT:  cover property (@(posedge clk_sys) ready_n_oe ##1 !on_q);
    COV_NEGF:  cover property (@(posedge clk_sys)
        ready_n_oe ##1 st_r == TRS_NEG);
endmodule
`default_nettype wire

// ===== bench/trs_rail_model.sv
// rail comparator and ready pull-up model facing the sequencer
`timescale 1ns/1ps
`default_nettype none
module trs_rail_model
(
    input  wire logic       clk_sys,
    input  wire logic       slow,
    input  wire logic [3:0] en,
    input  wire logic [3:0] kill,
    input  wire logic       ready_n_out,
    input  wire logic       ready_n_oe,
    output logic      [3:0] ok,
    output logic            ready_pin
);
    int age [4];
    // a rail reads good only after its stage has run a while
    always @(posedge clk_sys)
        for (int i = 0; i < 4; i++)
            age[i] <= en[i] ? age[i] + 1 : 0;
    always_comb
        for (int i = 0; i < 4; i++)
            ok[i] = age[i] > (slow ? 40 : 2) && !kill[i];
    // released line sits at the external pull-up level
    assign ready_pin = ready_n_oe ? ready_n_out : 1'b1;
endmodule
`default_nettype wire

// ===== bench/trs_sequencer_tb.sv
// self-checking bench for the triple rail sequencer
`timescale 1ns/1ps
`default_nettype none
module trs_sequencer_tb;
    localparam int OSC = 20;
    localparam int MAXON = 15;
    localparam int SS = 64;
    logic        clk_sys = 1'b0;
    logic        rst_b = 1'b0;
    logic        pwr_n = 1'b0;
    logic        trip = 1'b0;
    logic        slow = 1'b0;
    logic        sw_q = 1'b0;
    logic [3:0]  kill = 4'h0;
    logic [15:0] lfsr = 16'h5d66;
    int          err_count = 0;
    int          samples_checked = 0;
    int          on_cnt = 0, last_on = 0, gap = -1, rises = 0, trip_cnt = 0;
    int          run;
    int          ramp_hi = 0;
    wire  [3:0]  ok, en;
    wire         ref_gnd, sw, nh, nl, ph, pl, ramp, rdy_out, rdy_oe, rdy_pin;
    logic [4:0]  plan [$] = '{5'h10, 5'h14, 5'h10, 5'h18, 5'h10, 5'h12,
                              5'h10, 5'h11, 5'h00, 5'h10};

    always #5 clk_sys = ~clk_sys;

    trs_sequencer #(.OSC_CYC(OSC), .MAX_ON_CYC(MAXON), .SS_CYC(SS)) DUT (
        .clk_sys(clk_sys), .rst_b(rst_b), .power_off_n_input(pwr_n),
        .ref_ok(ok[0]), .boost_fb_ok(ok[1]), .neg_fb_ok(ok[2]),
        .neg_fb_fault(!ok[2]), .pos_fb_ok(ok[3]), .pos_fb_fault(!ok[3]),
        .boost_trip(trip), .ref_enable(en[0]), .ref_ground(ref_gnd),
        .boost_enable(en[1]), .boost_switch_node(sw),
        .neg_pump_enable(en[2]), .neg_pump_driver_hi(nh),
        .neg_pump_driver_lo(nl), .pos_pump_enable(en[3]),
        .pos_pump_driver_hi(ph), .pos_pump_driver_lo(pl),
        .pump_ramp_active(ramp), .ready_n_out(rdy_out), .ready_n_oe(rdy_oe)
    );
    trs_rail_model RAILS (
        .clk_sys(clk_sys), .slow(slow), .en(en), .kill(kill),
        .ready_n_out(rdy_out), .ready_n_oe(rdy_oe), .ok(ok),
        .ready_pin(rdy_pin)
    );

    task automatic cmp_lvl(input logic [4:0] got, input logic [4:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            err_count++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic cmp_cnt(input int got, input int exp);
        samples_checked++;
        if (got != exp)
        begin
            err_count++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic report_and_stop;
        if (err_count == 0 && samples_checked > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    function automatic logic [15:0] lfsr_nxt(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    // stage reached with a given supply and set of dead rails
    function automatic logic [4:0] exp_vec(input logic [4:0] e);
        int st;
        st = !e[4] ? 0 : e[0] ? 1 : e[1] ? 2 : e[2] ? 3 : e[3] ? 4 : 5;
        return 5'h1f >> (5 - st);
    endfunction
    task automatic settle(input logic [4:0] e);
        logic [4:0] x;
        int n;
        x = exp_vec(e);
        @(posedge clk_sys);
        #1;
        pwr_n = e[4];
        kill = e[3:0];
        for (n = 0; n < 600 && {rdy_oe, en} !== x; n++)
            @(negedge clk_sys);
        cmp_lvl({rdy_oe, en}, x);
        cmp_lvl({4'h0, rdy_pin}, {4'h0, !x[4]});
        if (n >= 600)
            report_and_stop();
    endtask

    always @(negedge clk_sys)
    begin
        if (rst_b)
        begin
            cmp_lvl({1'b0, en[1] & !en[0], en[2] & !en[1], en[3] & !en[2],
                     rdy_oe & !en[3]}, 5'h00);
            cmp_lvl({4'h0, ref_gnd}, {4'h0, !en[0]});
            cmp_lvl({3'h0, nh & nl, ph & pl}, 5'h00);
            cmp_lvl({4'h0, ramp & !en[2]}, 5'h00);
            ramp_hi = ramp_hi + (ramp ? 1 : 0);
            if (!en[0])
                cmp_lvl({sw & sw_q, nh, nl, ph, pl}, 5'h00);
            if (trip_cnt >= 8)
                cmp_lvl({4'h0, sw & sw_q}, 5'h00);
            gap = !en[1] ? -1 : (gap >= 0 ? gap + 1 : gap);
            if (sw && !sw_q)
            begin
                if (gap >= 0)
                    cmp_cnt(gap % OSC, 0);
                gap = 0;
                rises++;
            end
            if (!sw && sw_q)
                last_on = on_cnt;
            on_cnt = sw ? on_cnt + 1 : 0;
            if (sw)
                cmp_cnt(on_cnt > MAXON, 0);
        end
        sw_q = sw;
        trip_cnt = trip ? trip_cnt + 1 : 0;
    end

    initial
    begin
        repeat (6) @(posedge clk_sys);
        #1;
        rst_b = 1'b1;
        foreach (plan[i])
        begin
            slow = i[0];
            settle(plan[i]);
        end
        // comparator trips at random points of the switching period
        repeat (100)
        begin
            repeat (4) @(posedge clk_sys);
            #1;
            lfsr = lfsr_nxt(lfsr);
            trip = lfsr[0] & lfsr[3];
        end
        trip = 1'b0;
        repeat (10) @(posedge clk_sys);
        rises = 0;
        repeat (100) @(posedge clk_sys);
        cmp_cnt(rises, 100 / OSC);
        cmp_cnt(last_on, MAXON);
        for (run = 0; run < SS + 40 && ramp; run++)
            @(negedge clk_sys);
        cmp_lvl({4'h0, ramp}, 5'h00);
        cmp_cnt(ramp_hi > 0, 1);
        for (run = 0; run < 3 * OSC && nh; run++)
            @(negedge clk_sys);
        for (run = 0; run < 3 * OSC && !nh; run++)
            @(negedge clk_sys);
        cmp_lvl({nh, nl, ph, pl, 1'b0}, 5'h12);
        for (run = 0; run < 3 * OSC && nh; run++)
            @(negedge clk_sys);
        cmp_cnt(run, OSC);
        cmp_lvl({nh, nl, ph, pl, 1'b0}, 5'h0c);
        report_and_stop();
    end
endmodule
`default_nettype wire
